// >>> common/limit_pkg.sv
package limit_pkg;

	// register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int TQ_W   = 16;
	localparam int SPD_W  = 16;

	// register offsets (byte addresses, one word each)
	localparam logic [ADDR_W-1:0] OFS_MODE   = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_SELECT = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_ESTOP  = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

	// status field positions
	localparam int ST_ALARM   = 0;
	localparam int ST_WARN    = 1;
	localparam int ST_FWD_TRP = 2;
	localparam int ST_REV_TRP = 3;
	localparam int ST_PHASE   = 4;

	// settings: legal range tops and reset values
	localparam logic [1:0] MODE_MAX       = 2'h2;
	localparam logic [1:0] MODE_RST       = 2'h1;
	localparam logic [1:0] MODE_ENA_PAIR  = 2'h0;
	localparam logic [1:0] MODE_DISABLED  = 2'h1;
	localparam logic [1:0] MODE_ENA_EACH  = 2'h2;
	localparam logic [1:0] SEL_MAX        = 2'h2;
	localparam logic [1:0] SEL_RST        = 2'h0;
	localparam logic [1:0] SEL_BRAKE      = 2'h0;
	localparam logic [1:0] SEL_FREE       = 2'h1;
	localparam logic [1:0] SEL_ESTOP      = 2'h2;
	localparam logic [TQ_W-1:0] ESTOP_TQ_RST = 16'h0000;

	// speed at or below which the motor counts as stopped, in r/min
	localparam logic [SPD_W-1:0] STOP_SPEED_RPM = 16'h001e;

	// stop sequence phases
	typedef enum logic [1:0] {
		PH_RUN     = 2'b00,
		PH_DECEL   = 2'b01,
		PH_STOPPED = 2'b10
	} phase_e;

	// register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_s;

	// drive actions handed to the power stage and position loop
	typedef struct packed {
		logic            dyn_brake;
		logic            free_run;
		logic            estop;
		logic [TQ_W-1:0] torque_limit;
		logic            zero_tq_fwd;
		logic            zero_tq_rev;
		logic            cnt_clear;
		logic            cnt_hold;
	} stop_act_s;

endpackage

// >>> logic/travel_limit_supervisor.sv
// What this block does
// - input mode 0..2, reset 1, 1 disables
// - open forward input blocks forward travel only
// - open reverse input blocks reverse travel only
// - shorted input means no limit, normal
// - mode 0: both open raises alarm
// - mode 2: either open raises alarm
// - tripped limit decelerates then stops by selection
// - select 0: brake, clear; stopped: zero torque, hold
// - select 1: free-run, clear; stopped: zero torque, hold
// - select 2: e-stop, hold; stopped: clear once
// - decel ends at 30 r/min, never returns
// - e-stop keeps servo on, torque capped
// - stop select 0..2, reset 0, used on trip
// - warn on command toward blocked stopped direction
module travel_limit_supervisor
	import limit_pkg::*;
(
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	input  wire limit_pkg::reg_req_s         reg_req,
	output logic [limit_pkg::DATA_W-1:0]     reg_rdata,
	input  wire logic                        fwd_limit_in,
	input  wire logic                        rev_limit_in,
	input  wire logic signed [limit_pkg::SPD_W-1:0] motor_speed,
	input  wire logic                        cmd_fwd,
	input  wire logic                        cmd_rev,
	output logic                             fwd_block,
	output logic                             rev_block,
	output logic                             limit_alarm,
	output logic                             cmd_warning,
	output limit_pkg::stop_act_s             stop_act
);
	import limit_pkg::*;

	// whole state of the block
	typedef struct packed {
		logic              fwd_meta;
		logic              fwd_sync;
		logic              rev_meta;
		logic              rev_sync;
		logic [1:0]        limit_input_mode;
		logic [1:0]        limit_stop_select;
		logic [1:0]        run_sel;
		logic [TQ_W-1:0]   estop_torque_limit;
		phase_e            phase;
		logic              alarm;
		logic              warn;
		logic              fwd_block;
		logic              rev_block;
		logic [DATA_W-1:0] rdata;
		stop_act_s         act;
	} state_s;

	state_s state_r;
	state_s state_nxt;

	logic              enabled;
	logic              fwd_open;
	logic              rev_open;
	logic              fwd_trip;
	logic              rev_trip;
	logic              any_trip;
	logic [SPD_W-1:0]  speed_mag;
	logic              slow;
	logic              alarm_set;
	logic              warn_set;
	logic              alarm_clr;
	logic              warn_clr;
	logic [DATA_W-1:0] status_word;

	////////////////////////////////////////////////////////////////////////////////
	// condition decode from synchronised pins and the current state

	// a low pin level means the contact to the common return is open
	assign enabled   = (state_r.limit_input_mode != MODE_DISABLED);
	assign fwd_open  = ~state_r.fwd_sync;
	assign rev_open  = ~state_r.rev_sync;
	assign fwd_trip  = enabled & fwd_open;
	assign rev_trip  = enabled & rev_open;
	assign any_trip  = fwd_trip | rev_trip;

	// two's complement magnitude; the most negative value reads as 0x8000, still fast
	assign speed_mag = motor_speed[SPD_W-1] ? SPD_W'(-motor_speed) : SPD_W'(motor_speed);
	assign slow      = (speed_mag <= STOP_SPEED_RPM);

	// pairing fault in mode 0, any open contact in mode 2
	assign alarm_set = ((state_r.limit_input_mode == MODE_ENA_PAIR) & fwd_open & rev_open)
		| ((state_r.limit_input_mode == MODE_ENA_EACH) & (fwd_open | rev_open));

	// a motion command into a closed direction while standing still
	assign warn_set  = slow & ((cmd_fwd & fwd_trip) | (cmd_rev & rev_trip));

	// write-one-to-clear on the status word
	assign alarm_clr = reg_req.wr & (reg_req.addr == OFS_STATUS) & reg_req.wdata[ST_ALARM];
	assign warn_clr  = reg_req.wr & (reg_req.addr == OFS_STATUS) & reg_req.wdata[ST_WARN];

	// status word as software sees it
	always_comb begin
		status_word                              = '0;
		status_word[ST_ALARM]                    = state_r.alarm;
		status_word[ST_WARN]                     = state_r.warn;
		status_word[ST_FWD_TRP]                  = fwd_trip;
		status_word[ST_REV_TRP]                  = rev_trip;
		status_word[ST_PHASE +: 2]               = state_r.phase;
	end

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		state_nxt = state_r;

		// pins pass two flops; only the second stage is looked at
		state_nxt.fwd_meta = fwd_limit_in;
		state_nxt.fwd_sync = state_r.fwd_meta;
		state_nxt.rev_meta = rev_limit_in;
		state_nxt.rev_sync = state_r.rev_meta;

		// settings writes; out-of-range values are dropped so a setting stays legal
		if (reg_req.wr) begin
			case (reg_req.addr)
				OFS_MODE: begin
					if (reg_req.wdata[1:0] <= MODE_MAX && reg_req.wdata[DATA_W-1:2] == '0) begin
						state_nxt.limit_input_mode = reg_req.wdata[1:0];
					end
				end
				OFS_SELECT: begin
					if (reg_req.wdata[1:0] <= SEL_MAX && reg_req.wdata[DATA_W-1:2] == '0) begin
						state_nxt.limit_stop_select = reg_req.wdata[1:0];
					end
				end
				OFS_ESTOP: begin
					state_nxt.estop_torque_limit = reg_req.wdata[TQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// read data stands only in the cycle after the strobe
		state_nxt.rdata = '0;
		if (reg_req.rd) begin
			case (reg_req.addr)
				OFS_MODE:   state_nxt.rdata = {{(DATA_W-2){1'b0}}, state_r.limit_input_mode};
				OFS_SELECT: state_nxt.rdata = {{(DATA_W-2){1'b0}}, state_r.limit_stop_select};
				OFS_ESTOP:  state_nxt.rdata = {{(DATA_W-TQ_W){1'b0}}, state_r.estop_torque_limit};
				OFS_STATUS: state_nxt.rdata = status_word;
				default:    state_nxt.rdata = '0;
			endcase
		end

		// sticky flags: a new event in the clearing cycle keeps the flag set
		state_nxt.alarm = alarm_set | (state_r.alarm & ~alarm_clr);
		state_nxt.warn  = warn_set | (state_r.warn & ~warn_clr);

		// direction blocks follow the contacts and never touch the far direction
		state_nxt.fwd_block = fwd_trip;
		state_nxt.rev_block = rev_trip;

		// stop sequence; the selection is frozen at the trip so a mid-stop write
		// cannot switch braking style under a moving load
		case (state_r.phase)
			PH_RUN: begin
				if (any_trip) begin
					state_nxt.run_sel = state_r.limit_stop_select;
					state_nxt.phase   = slow ? PH_STOPPED : PH_DECEL;
				end
			end
			PH_DECEL: begin
				if (!enabled) begin
					state_nxt.phase = PH_RUN;
				end else if (slow) begin
					state_nxt.phase = PH_STOPPED;
				end
			end
			PH_STOPPED: begin
				// no speed check here: a later speed rise keeps the stopped behaviour
				if (!any_trip) begin
					state_nxt.phase = PH_RUN;
				end
			end
			default: begin
				state_nxt.phase = PH_RUN;
			end
		endcase

		// drive actions for the phase being entered
		state_nxt.act              = '0;
		state_nxt.act.torque_limit = '0;
		case (state_nxt.phase)
			PH_DECEL: begin
				case (state_nxt.run_sel)
					SEL_BRAKE: begin
						state_nxt.act.dyn_brake = 1'b1;
						state_nxt.act.cnt_clear = 1'b1;
					end
					SEL_FREE: begin
						state_nxt.act.free_run  = 1'b1;
						state_nxt.act.cnt_clear = 1'b1;
					end
					default: begin
						// servo stays energised, torque capped by the setting
						state_nxt.act.estop        = 1'b1;
						state_nxt.act.torque_limit = state_r.estop_torque_limit;
						state_nxt.act.cnt_hold     = 1'b1;
					end
				endcase
			end
			PH_STOPPED: begin
				if (state_nxt.run_sel == SEL_ESTOP) begin
					// normal torque; one clear on entry, hold afterwards
					state_nxt.act.cnt_clear = (state_r.phase != PH_STOPPED);
					state_nxt.act.cnt_hold  = (state_r.phase == PH_STOPPED);
				end else begin
					state_nxt.act.zero_tq_fwd = fwd_trip;
					state_nxt.act.zero_tq_rev = rev_trip;
					state_nxt.act.cnt_hold    = 1'b1;
				end
			end
			default: begin
			end
		endcase

		// synchronous reset to the documented settings
		if (!rstn) begin
			state_nxt                    = '0;
			state_nxt.fwd_meta           = 1'b1;
			state_nxt.fwd_sync           = 1'b1;
			state_nxt.rev_meta           = 1'b1;
			state_nxt.rev_sync           = 1'b1;
			state_nxt.limit_input_mode   = MODE_RST;
			state_nxt.limit_stop_select  = SEL_RST;
			state_nxt.run_sel            = SEL_RST;
			state_nxt.estop_torque_limit = ESTOP_TQ_RST;
			state_nxt.phase              = PH_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// sync stages reset to "shorted" so a reset never fakes a trip
	always_ff @(posedge clk_sys) begin
		state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from state flops

	assign reg_rdata   = state_r.rdata;
	assign fwd_block   = state_r.fwd_block;
	assign rev_block   = state_r.rev_block;
	assign limit_alarm = state_r.alarm;
	assign cmd_warning = state_r.warn;
	assign stop_act    = state_r.act;

endmodule

// >>> verification/limit_switch_model.sv
module limit_switch_model (
	input  wire logic clk_sys,
	input  wire logic fwd_open,
	input  wire logic rev_open,
	output logic      fwd_limit_in = 1'b1,
	output logic      rev_limit_in = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	// contacts move 7 ns after the edge, so the pins never line up with the clock
	always @(posedge clk_sys) begin
		fwd_limit_in <= #7 !fwd_open;
		rev_limit_in <= #7 !rev_open;
	end
endmodule

// >>> verification/travel_limit_supervisor_props.sv
module travel_limit_supervisor_props
	import limit_pkg::*;
(
	input wire logic                                 clk_sys,
	input wire logic                                 rstn,
	input wire limit_pkg::reg_req_s                  reg_req,
	input wire logic                                 fwd_limit_in,
	input wire logic                                 rev_limit_in,
	input wire logic signed [limit_pkg::SPD_W-1:0]   motor_speed,
	input wire logic                                 cmd_fwd,
	input wire logic                                 fwd_block,
	input wire logic                                 rev_block,
	input wire logic                                 limit_alarm,
	input wire logic                                 cmd_warning,
	input wire limit_pkg::stop_act_s                 stop_act
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [1:0]  mode_r, mp;
	logic [15:0] tq_r;
	logic [2:0]  fsh, rsh;
	logic        on, fo, ro, slow, mv;
	// settings shadow, so pin rules can be judged from the ports alone
	always_ff @(posedge clk_sys) begin
		fsh <= {fsh[1:0], fwd_limit_in};
		rsh <= {rsh[1:0], rev_limit_in};
		mp <= mode_r;
		if (!rstn) begin
			mode_r <= MODE_RST;
			tq_r <= ESTOP_TQ_RST;
		end else if (reg_req.wr && reg_req.addr == OFS_MODE && reg_req.wdata <= 32'h2)
			mode_r <= reg_req.wdata[1:0];
		else if (reg_req.wr && reg_req.addr == OFS_ESTOP)
			tq_r <= reg_req.wdata[15:0];
	end
	// open for two samples, so the decision three edges later is settled
	assign fo = !fsh[1] && !fsh[2];
	assign ro = !rsh[1] && !rsh[2];
	assign on = mode_r != MODE_DISABLED && mp != MODE_DISABLED;
	assign slow = motor_speed <= 16'sh001e && motor_speed >= -16'sh001e;
	assign mv = stop_act.dyn_brake || stop_act.free_run || stop_act.estop;
	property p_fwd; on && fo |-> fwd_block; endproperty
	a_fwd: assert property (p_fwd) else $error("fwd block missing");
	property p_rev; on && ro |-> rev_block; endproperty
	a_rev: assert property (p_rev) else $error("rev block missing");
	property p_off; !on && mp == MODE_DISABLED |-> !fwd_block && !rev_block; endproperty
	a_off: assert property (p_off) else $error("block while disabled");
	property p_pair; mode_r == 2'h0 && mp == 2'h0 && fo && ro |-> limit_alarm; endproperty
	a_pair: assert property (p_pair) else $error("pair alarm missing");
	property p_each; mode_r == 2'h2 && mp == 2'h2 && (fo || ro) |-> limit_alarm; endproperty
	a_each: assert property (p_each) else $error("single alarm missing");
	property p_brk; stop_act.dyn_brake |-> stop_act.cnt_clear && !stop_act.cnt_hold; endproperty
	a_brk: assert property (p_brk) else $error("brake counter wrong");
	property p_es; stop_act.estop |-> stop_act.cnt_hold && stop_act.torque_limit == tq_r; endproperty
	a_es: assert property (p_es) else $error("estop wrong");
	property p_slow; mv && slow |=> !mv; endproperty
	a_slow: assert property (p_slow) else $error("decel not ended");
	property p_warn; on && fo && cmd_fwd && slow |=> cmd_warning; endproperty
	a_warn: assert property (p_warn) else $error("warning missing");
	c_brk: cover property (stop_act.dyn_brake);
	c_es: cover property (stop_act.estop);
	c_warn: cover property (cmd_warning);
endmodule
bind travel_limit_supervisor travel_limit_supervisor_props i_props (.clk_sys(clk_sys),
	.rstn(rstn), .reg_req(reg_req), .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
	.motor_speed(motor_speed), .cmd_fwd(cmd_fwd), .fwd_block(fwd_block), .rev_block(rev_block),
	.limit_alarm(limit_alarm), .cmd_warning(cmd_warning), .stop_act(stop_act));

// >>> verification/test_travel_limit_supervisor.sv
module test_travel_limit_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	import limit_pkg::*;
	logic              clk_sys = 1'b0;
	logic              rstn = 1'b0;
	reg_req_s          reg_req = '0;
	logic [31:0]       reg_rdata;
	logic              fwd_open = 1'b0, rev_open = 1'b0, fwd_limit_in, rev_limit_in;
	logic signed [15:0] motor_speed = '0;
	logic              cmd_fwd = 1'b0, cmd_rev = 1'b0, fwd_block, rev_block;
	logic              limit_alarm, cmd_warning;
	stop_act_s         stop_act;
	int                failures = 0, checks_done = 0, cycles = 0, seed = 26423;
	travel_limit_supervisor i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
		.motor_speed(motor_speed), .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev), .fwd_block(fwd_block),
		.rev_block(rev_block), .limit_alarm(limit_alarm), .cmd_warning(cmd_warning),
		.stop_act(stop_act));
	limit_switch_model i_sw (.clk_sys(clk_sys), .fwd_open(fwd_open), .rev_open(rev_open),
		.fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in));
	////////////////////////////////////////////////////////////////////////////////
	initial forever #10 clk_sys = ~clk_sys;
	// a hang ends the run as a failure
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(string name, logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// look just after the edge, once its updates have landed
	task automatic look(int n);
		tick(n);
		#1;
	endtask
	// each access waits for an edge first, so a strobe is never set and cleared in one step
	task automatic wr(logic [3:0] a, logic [31:0] d);
		tick(1);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		tick(1);
		reg_req.wr <= 1'b0;
	endtask
	task automatic rc(logic [3:0] a, logic [31:0] exp, string name);
		tick(1);
		reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		tick(1);
		// strobe drops right at the taking edge; data stand until the next edge
		reg_req.rd <= 1'b0;
		#1;
		check(name, reg_rdata, exp);
	endtask
	// drive actions expected in each phase
	function automatic stop_act_s exp_act(logic [1:0] sel, phase_e ph, logic d, logic [15:0] tq);
		stop_act_s a;
		a = '0;
		if (ph == PH_DECEL) begin
			a.dyn_brake = sel == SEL_BRAKE;
			a.free_run = sel == SEL_FREE;
			a.estop = sel == SEL_ESTOP;
			a.torque_limit = a.estop ? tq : 16'h0000;
			a.cnt_clear = !a.estop;
			a.cnt_hold = a.estop;
		end else if (ph == PH_STOPPED) begin
			a.zero_tq_fwd = sel != SEL_ESTOP && !d;
			a.zero_tq_rev = sel != SEL_ESTOP && d;
			a.cnt_hold = 1'b1;
		end
		return a;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [1:0]  m, sel;
		logic [15:0] tq;
		logic        d;
		tick(2);
		rstn <= 1'b1;
		rc(OFS_MODE, 32'h1, "mode");
		rc(OFS_SELECT, 32'h0, "select");
		wr(OFS_MODE, 32'h3);
		wr(OFS_SELECT, 32'h3);
		rc(OFS_MODE, 32'h1, "mode");
		rc(OFS_SELECT, 32'h0, "select");
		rc(4'h2, 32'h0, "unmapped");
		// both contacts open: ignored while disabled, then both block and alarm
		fwd_open <= 1'b1;
		rev_open <= 1'b1;
		look(6);
		check("disabled", 32'({fwd_block, rev_block, limit_alarm}), 32'h0);
		wr(OFS_MODE, 32'h0);
		look(6);
		check("pair", 32'({fwd_block, rev_block, limit_alarm}), 32'h7);
		tick(1);
		fwd_open <= 1'b0;
		rev_open <= 1'b0;
		tick(6);
		wr(OFS_STATUS, 32'h3);
		// both enabling modes (0 and 2) and every selection, random side, torque and speed
		for (int i = 0; i < 6; i++) begin
			m = (i < 3) ? MODE_ENA_PAIR : MODE_ENA_EACH;
			sel = 2'(i % 3);
			d = 1'($random(seed));
			tq = 16'($random(seed));
			wr(OFS_MODE, 32'(m));
			wr(OFS_SELECT, 32'(sel));
			wr(OFS_ESTOP, 32'(tq));
			tick(1);
			motor_speed <= 16'sh0064 + 16'($random(seed) & 32'h3ff);
			cmd_fwd <= !d;
			cmd_rev <= d;
			fwd_open <= !d;
			rev_open <= d;
			look(6);
			check("block", 32'({fwd_block, rev_block}), 32'({!d, d}));
			check("flags", 32'({cmd_warning, limit_alarm}), 32'(m == MODE_ENA_EACH));
			check("decel", 32'(stop_act), 32'(exp_act(sel, PH_DECEL, d, tq)));
			tick(1);
			motor_speed <= 16'($random(seed) % 31);
			look(1);
			// e-stop entry clears the counter once instead of holding it
			check("entry", 32'(stop_act), 32'(exp_act(sel, PH_STOPPED, d, tq)) ^ ((sel == SEL_ESTOP) ? 32'h3 : 32'h0));
			look(7);
			check("stop", 32'(stop_act), 32'(exp_act(sel, PH_STOPPED, d, tq)));
			check("warn", 32'(cmd_warning), 32'h1);
			tick(1);
			motor_speed <= -16'sh0200;
			look(4);
			check("stay", 32'(stop_act), 32'(exp_act(sel, PH_STOPPED, d, tq)));
			rc(OFS_STATUS, 32'({PH_STOPPED, d, !d, 1'b1, m == MODE_ENA_EACH}), "status");
			tick(1);
			fwd_open <= 1'b0;
			rev_open <= 1'b0;
			look(6);
			check("release", 32'({fwd_block, rev_block, stop_act}), 32'h0);
			wr(OFS_STATUS, 32'h3);
		end
		complete_run();
	end
endmodule
